/* hw/iof_input_filter.sv */
// iof_input_filter: per-line input filters and pin level status registers
// Functional notes
// - level status shows every line's filtered level
// - status holds while controller clock is off
// - filter programmable per line, lines independent
// - set/clear registers choose mode, status readable
// - status 0: glitch filter on system clock
// - status 1: debounce on divided slow clock
// - divided period is 2*(div+1) slow periods
// - pulses under half period are rejected
// - pulses of one period or more pass
// - pulses between half and one: either outcome
`timescale 1ns/1ps
module iof_input_filter
   import iof_pkg::*;
#(
   parameter int unsigned N_LINES = IOF_LINES,
   parameter int unsigned DIV_W   = IOF_DIV_W
)(
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic [IOF_ADDR_W-1:0] reg_addr,
   input  wire logic [IOF_DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [IOF_DATA_W-1:0] reg_rdata_q,
   input  wire logic [N_LINES-1:0]    io_in,
   input  wire logic                  slow_clk_in,
   input  wire logic                  ctrl_clk_en,
   output logic      [N_LINES-1:0]    filt_out_q
);

   // ***********************************************************
   // declarations
   // ***********************************************************
   logic [N_LINES-1:0]    filt_en_q;
   logic [N_LINES-1:0]    sel_q;
   logic [DIV_W-1:0]      div_q;
   logic [N_LINES-1:0]    level_q;
   logic [DIV_W-1:0]      cnt_q;
   logic                  slck_q;
   logic                  slck_rise;
   logic                  tick_q;
   logic [N_LINES-1:0]    samp_w;
   logic [N_LINES-1:0]    filt_w;
   logic [N_LINES-1:0]    wr_bits;
   logic [IOF_DATA_W-1:0] rdata_d;

   assign wr_bits   = reg_wdata[N_LINES-1:0];
   assign slck_rise = slow_clk_in & ~slck_q;

   // ***********************************************************
   // filter enable registers
   // ***********************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         filt_en_q <= IOF_FILT_EN_RST[N_LINES-1:0];
      end else if (reg_wr && (reg_addr == IOF_FILT_EN_SET)) begin
         filt_en_q <= filt_en_q | wr_bits;
      end else if (reg_wr && (reg_addr == IOF_FILT_EN_CLEAR)) begin
         filt_en_q <= filt_en_q & ~wr_bits;
      end
   end

   // ***********************************************************
   // mode selection registers
   // ***********************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sel_q <= IOF_SEL_RST[N_LINES-1:0];
      end else if (reg_wr && (reg_addr == IOF_SEL_SET)) begin
         sel_q <= sel_q | wr_bits;
      end else if (reg_wr && (reg_addr == IOF_SEL_CLEAR)) begin
         sel_q <= sel_q & ~wr_bits;
      end
   end

   // ***********************************************************
   // divider register
   // ***********************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= IOF_DIV_RST[DIV_W-1:0];
      end else if (reg_wr && (reg_addr == IOF_DIV_REG)) begin
         div_q <= reg_wdata[IOF_DIV_LSB +: DIV_W];
      end
   end

   // ***********************************************************
   // divided slow clock
   // ***********************************************************
   // the tick marks each half period of the divided clock, i.e.
   // every div+1 rising edges of the slow clock
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         slck_q <= 1'b0;
      end else begin
         slck_q <= slow_clk_in;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (slck_rise && (cnt_q >= div_q)) begin
         cnt_q  <= '0;
         tick_q <= 1'b1;
      end else if (slck_rise) begin
         cnt_q  <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
      end
   end

   // ***********************************************************
   // per-line filters
   // ***********************************************************
   for (genvar i = 0; i < N_LINES; i++) begin : g_line
      iof_line_filter u_filt (
         .clk_sys  (clk_sys),
         .sys_rst  (sys_rst),
         .pin_in   (io_in[i]),
         .filt_en  (filt_en_q[i]),
         .deb_sel  (sel_q[i]),
         .deb_tick (tick_q),
         .samp_q   (samp_w[i]),
         .filt_q   (filt_w[i])
      );
   end

   assign filt_out_q = filt_w;

   // ***********************************************************
   // pin level status
   // ***********************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= IOF_LEVEL_RST[N_LINES-1:0];
      end else if (ctrl_clk_en) begin
         level_q <= filt_w;
      end
   end

   // ***********************************************************
   // read port
   // ***********************************************************
   always_comb begin
      rdata_d = '0;
      case (reg_addr)
         IOF_FILT_EN_STATUS: begin
            rdata_d[N_LINES-1:0] = filt_en_q;
         end
         IOF_SEL_STATUS: begin
            rdata_d[N_LINES-1:0] = sel_q;
         end
         IOF_DIV_REG: begin
            rdata_d[IOF_DIV_LSB +: DIV_W] = div_q;
         end
         IOF_PIN_LEVEL: begin
            rdata_d[N_LINES-1:0] = level_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_q <= IOF_RDATA_RST;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= '0;
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   property p_level_track;
      @(posedge clk_sys) disable iff (sys_rst)
      ctrl_clk_en |=> (level_q == $past(filt_w));
   endproperty
   a_level_track: assert property (p_level_track)
      else $error("level status does not follow filtered lines");

   property p_level_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      (!ctrl_clk_en) [*2] |-> $stable(level_q);
   endproperty
   a_level_hold: assert property (p_level_hold)
      else $error("level status changed while clock off");

   property p_en_set_only;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && (reg_addr == IOF_FILT_EN_SET)) |=>
         ((filt_en_q & ~$past(wr_bits)) ==
          ($past(filt_en_q) & ~$past(wr_bits)))
         && ((filt_en_q & $past(wr_bits)) == $past(wr_bits));
   endproperty
   a_en_set_only: assert property (p_en_set_only)
      else $error("enable set disturbed other lines");

   property p_sel_set;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && (reg_addr == IOF_SEL_SET)) |=>
         ((sel_q & $past(wr_bits)) == $past(wr_bits))
         && ((sel_q & ~$past(wr_bits)) ==
             ($past(sel_q) & ~$past(wr_bits)));
   endproperty
   a_sel_set: assert property (p_sel_set)
      else $error("select set wrong");

   property p_sel_clear;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && (reg_addr == IOF_SEL_CLEAR)) |=>
         ((sel_q & $past(wr_bits)) == '0)
         && ((sel_q & ~$past(wr_bits)) ==
             ($past(sel_q) & ~$past(wr_bits)));
   endproperty
   a_sel_clear: assert property (p_sel_clear)
      else $error("select clear wrong");

   property p_sel_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd && (reg_addr == IOF_SEL_STATUS)) |=>
         (reg_rdata_q[N_LINES-1:0] == $past(sel_q));
   endproperty
   a_sel_read: assert property (p_sel_read)
      else $error("select status read wrong");

   property p_glitch_pass;
      @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> (((filt_w ^ $past(io_in)) &
                 $past(filt_en_q & ~sel_q)) == '0);
   endproperty
   a_glitch_pass: assert property (p_glitch_pass)
      else $error("glitch mode line not on system clock");

   property p_deb_only_tick;
      @(posedge clk_sys) disable iff (sys_rst)
      !tick_q |=> (((filt_w ^ $past(filt_w)) &
                    $past(filt_en_q & sel_q)) == '0);
   endproperty
   a_deb_only_tick: assert property (p_deb_only_tick)
      else $error("debounce line changed off the tick");

   property p_tick_spacing;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q |-> $past(slck_rise) && ($past(cnt_q) >= $past(div_q));
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("divided clock tick at wrong slow edge");

   property p_reject_short;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q |=> (((filt_w ^ $past(filt_w)) &
                   $past(filt_en_q & sel_q & (io_in ^ samp_w))) == '0);
   endproperty
   a_reject_short: assert property (p_reject_short)
      else $error("single sample accepted by debounce");

   property p_pass_long;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q |=> (((filt_w ^ $past(io_in)) &
                   $past(filt_en_q & sel_q & ~(io_in ^ samp_w))) == '0);
   endproperty
   a_pass_long: assert property (p_pass_long)
      else $error("stable debounce input not passed");

   property p_bypass;
      @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> (((filt_w ^ $past(io_in)) & $past(~filt_en_q)) == '0);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("unfiltered line does not follow input");

   property p_unmapped;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd && (reg_addr > IOF_PIN_LEVEL)) |=> (reg_rdata_q == '0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   property p_en_clear_only;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && (reg_addr == IOF_FILT_EN_CLEAR)) |=>
         ((filt_en_q & $past(wr_bits)) == '0)
         && ((filt_en_q & ~$past(wr_bits)) ==
             ($past(filt_en_q) & ~$past(wr_bits)));
   endproperty
   a_en_clear_only: assert property (p_en_clear_only)
      else $error("enable clear disturbed other lines");

   property p_div_write;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_wr && (reg_addr == IOF_DIV_REG)) |=>
         (div_q == $past(reg_wdata[IOF_DIV_LSB +: DIV_W]));
   endproperty
   a_div_write: assert property (p_div_write)
      else $error("divider write not taken");

   property p_level_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (reg_rd && (reg_addr == IOF_PIN_LEVEL)) |=>
         (reg_rdata_q[N_LINES-1:0] == $past(level_q));
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("level status read wrong");

   property p_rdata_idle;
      @(posedge clk_sys) disable iff (sys_rst)
      !reg_rd |=> (reg_rdata_q == '0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");

   // ***********************************************************
   // covers
   // ***********************************************************
   property p_cov_tick;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q ##[1:1000] tick_q;
   endproperty
   c_cov_tick: cover property (p_cov_tick);

   property p_cov_deb_change;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q && ((filt_en_q & sel_q) != '0) ##1 $changed(filt_w);
   endproperty
   c_cov_deb_change: cover property (p_cov_deb_change);

   property p_cov_hold_read;
      @(posedge clk_sys) disable iff (sys_rst)
      !ctrl_clk_en && reg_rd && (reg_addr == IOF_PIN_LEVEL);
   endproperty
   c_cov_hold_read: cover property (p_cov_hold_read);

   property p_cov_glitch;
      @(posedge clk_sys) disable iff (sys_rst)
      ((filt_en_q & ~sel_q) != '0) ##1 $changed(filt_w);
   endproperty
   c_cov_glitch: cover property (p_cov_glitch);

   property p_cov_mid_div;
      @(posedge clk_sys) disable iff (sys_rst)
      tick_q && (div_q != '0);
   endproperty
   c_cov_mid_div: cover property (p_cov_mid_div);

endmodule

/* hw/iof_pkg.sv */
// iof_pkg: register map, field layout and reset values of the input filter
package iof_pkg;

   // ***********************************************************
   // sizes
   // ***********************************************************
   localparam int unsigned IOF_ADDR_W     = 8;
   localparam int unsigned IOF_DATA_W     = 32;
   localparam int unsigned IOF_LINES      = 32;
   localparam int unsigned IOF_DIV_W      = 14;

   // ***********************************************************
   // register byte offsets
   // ***********************************************************
   localparam logic [7:0] IOF_FILT_EN_SET    = 8'h00;
   localparam logic [7:0] IOF_FILT_EN_CLEAR  = 8'h04;
   localparam logic [7:0] IOF_FILT_EN_STATUS = 8'h08;
   localparam logic [7:0] IOF_SEL_CLEAR      = 8'h0c;
   localparam logic [7:0] IOF_SEL_SET        = 8'h10;
   localparam logic [7:0] IOF_SEL_STATUS     = 8'h14;
   localparam logic [7:0] IOF_DIV_REG        = 8'h18;
   localparam logic [7:0] IOF_PIN_LEVEL      = 8'h1c;

   // ***********************************************************
   // field layout
   // ***********************************************************
   localparam int unsigned IOF_DIV_LSB       = 0;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [31:0] IOF_FILT_EN_RST   = 32'h0000_0000;
   localparam logic [31:0] IOF_SEL_RST       = 32'h0000_0000;
   localparam logic [31:0] IOF_DIV_RST       = 32'h0000_0000;
   localparam logic [31:0] IOF_LEVEL_RST     = 32'h0000_0000;
   localparam logic [31:0] IOF_RDATA_RST     = 32'h0000_0000;

endpackage

/* hw/iof_line_filter.sv */
// iof_line_filter: glitch or debounce filter for one input line
`timescale 1ns/1ps
module iof_line_filter
   import iof_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   input  wire logic filt_en,
   input  wire logic deb_sel,
   input  wire logic deb_tick,
   output logic      samp_q,
   output logic      filt_q
);

   // ***********************************************************
   // debounce sample, taken once per half divided period
   // ***********************************************************
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         samp_q <= 1'b0;
      end else if (deb_tick) begin
         samp_q <= pin_in;
      end
   end

   // ***********************************************************
   // filtered level
   // ***********************************************************
   // a change needs two consecutive equal samples half a period
   // apart: shorter than half a period never spans two samples,
   // a full period always does; in between depends on phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         filt_q <= 1'b0;
      end else if (!filt_en) begin
         filt_q <= pin_in;
      end else if (!deb_sel) begin
         filt_q <= pin_in;
      end else if (deb_tick && (pin_in == samp_q)) begin
         filt_q <= pin_in;
      end
   end

endmodule

/* sim/iof_pin_model.sv */
// iof_pin_model: external input lines and free-running slow clock source
`timescale 1ns/1ps
module iof_pin_model
#(
   parameter int unsigned SLOW_HALF = 4
)(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [31:0] pin_drive,
   output logic      [31:0] io_in,
   output logic             slow_clk_in
);
   // ***********************************************************
   // lines and slow clock
   // ***********************************************************
   logic [7:0] half_cnt_q;

   // lines are driven synchronously to the system clock
   assign io_in = pin_drive;

   // slow clock period is 2*SLOW_HALF system clock cycles
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         half_cnt_q  <= 8'h00;
         slow_clk_in <= 1'b0;
      end else if (half_cnt_q >= 8'(SLOW_HALF - 1)) begin
         half_cnt_q  <= 8'h00;
         slow_clk_in <= ~slow_clk_in;
      end else begin
         half_cnt_q <= half_cnt_q + 8'h01;
      end
   end
endmodule

/* sim/iof_input_filter_bench.sv */
// iof_input_filter_bench: register, level status and filter tests
`timescale 1ns/1ps
module iof_input_filter_bench
   import iof_pkg::*;
;
   // ***********************************************************
   // signals and instances
   // ***********************************************************
   logic                  clk_sys     = 1'b0;
   logic                  sys_rst     = 1'b1;
   logic [IOF_ADDR_W-1:0] reg_addr    = '0;
   logic [IOF_DATA_W-1:0] reg_wdata   = '0;
   logic                  reg_wr      = 1'b0;
   logic                  reg_rd      = 1'b0;
   logic [IOF_DATA_W-1:0] reg_rdata_q;
   logic [31:0]           pin_drive   = '0;
   logic [31:0]           io_in;
   logic                  slow_clk_in;
   logic                  ctrl_clk_en = 1'b1;
   logic [31:0]           filt_out_q;
   logic [31:0]           seen;
   int                    miscompares = 0;
   int                    checks_done = 0;

   always #12.5 clk_sys = ~clk_sys;

   iof_input_filter #(.N_LINES(32), .DIV_W(IOF_DIV_W)) uut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .io_in(io_in),
      .slow_clk_in(slow_clk_in), .ctrl_clk_en(ctrl_clk_en),
      .filt_out_q(filt_out_q));

   iof_pin_model #(.SLOW_HALF(4)) u_pins (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .pin_drive(pin_drive),
      .io_in(io_in), .slow_clk_in(slow_clk_in));

   // ***********************************************************
   // tasks
   // ***********************************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(what, exp, reg_rdata_q);
   endtask

   // drive lines high for len cycles and collect any filtered high
   task automatic pulse(input logic [31:0] m, input int len);
      seen = '0;
      @(posedge clk_sys);
      pin_drive <= m;
      for (int i = 0; i < len + 120; i++) begin
         @(posedge clk_sys);
         if (i == len - 1)
            pin_drive <= '0;
         seen |= filt_out_q;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rd_chk("enable status", IOF_FILT_EN_STATUS, IOF_FILT_EN_RST);
      rd_chk("select status", IOF_SEL_STATUS, IOF_SEL_RST);
      rd_chk("divider", IOF_DIV_REG, IOF_DIV_RST);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      rd_chk("select set read", IOF_SEL_SET, 32'h0000_0000);
      $display("test reset values done");

      @(posedge clk_sys);
      pin_drive <= 32'ha5c3_0f96;
      repeat (4) @(posedge clk_sys);
      rd_chk("level", IOF_PIN_LEVEL, 32'ha5c3_0f96);
      @(posedge clk_sys);
      ctrl_clk_en <= 1'b0;
      repeat (2) @(posedge clk_sys);
      pin_drive <= 32'h5a3c_f069;
      repeat (4) @(posedge clk_sys);
      rd_chk("level frozen", IOF_PIN_LEVEL, 32'ha5c3_0f96);
      @(posedge clk_sys);
      ctrl_clk_en <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd_chk("level resumed", IOF_PIN_LEVEL, 32'h5a3c_f069);
      @(posedge clk_sys);
      pin_drive <= '0;
      repeat (4) @(posedge clk_sys);
      $display("test level status done");

      // line 0 debounce, line 1 glitch, line 2 unfiltered
      wr(IOF_FILT_EN_SET, 32'h0000_0003);
      wr(IOF_SEL_SET, 32'h0000_0001);
      rd_chk("enable status", IOF_FILT_EN_STATUS, 32'h0000_0003);
      rd_chk("select status", IOF_SEL_STATUS, 32'h0000_0001);
      wr(IOF_DIV_REG, 32'hffff_ffff);
      rd_chk("divider width", IOF_DIV_REG, 32'h0000_3fff);
      pulse(32'h0000_0006, 1);
      chk("one cycle pulse", 32'h0000_0006, seen);
      for (int d = 0; d < 3; d++) begin
         wr(IOF_DIV_REG, 32'(d));
         repeat (60) @(posedge clk_sys);
         pulse(32'h0000_0007, (d + 1) * 8 - 2);
         chk("short pulse", 32'h0000_0006, seen);
         pulse(32'h0000_0007, (d + 1) * 16 + 8);
         chk("long pulse", 32'h0000_0007, seen);
      end
      // steady level: debounced line lags, the others follow at once
      @(posedge clk_sys);
      pin_drive <= 32'h0000_0007;
      @(posedge clk_sys);
      rd_chk("level filtered", IOF_PIN_LEVEL, 32'h0000_0006);
      repeat (60) @(posedge clk_sys);
      rd_chk("level debounced", IOF_PIN_LEVEL, 32'h0000_0007);
      @(posedge clk_sys);
      pin_drive <= '0;
      $display("test debounce done");

      wr(IOF_SEL_CLEAR, 32'h0000_0001);
      rd_chk("select cleared", IOF_SEL_STATUS, 32'h0000_0000);
      pulse(32'h0000_0001, 2);
      chk("glitch mode pulse", 32'h0000_0001, seen);
      wr(IOF_FILT_EN_CLEAR, 32'h0000_0003);
      rd_chk("enable cleared", IOF_FILT_EN_STATUS, 32'h0000_0000);
      $display("test mode switch done");
      finish_test();
   end

   // watchdog: tests take about 1500 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      finish_test();
   end
endmodule
